// ---- flag_if.sv ----
`timescale 1ns/1ps

// Comparator flags before and after synchronisation
interface flag_if;
	seq_pkg::flag_vec_type raw;
	seq_pkg::flag_vec_type synced;

	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface

// ---- flag_sync.sv ----
`timescale 1ns/1ps

module flag_sync
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Flags
	flag_if.sync_side fl
);
	flag_vec_type meta_q;
	flag_vec_type sync_q;

	// Two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= fl.raw;
			sync_q <= meta_q;
		end
	end

	assign fl.synced = sync_q;
endmodule

// ---- seq_analog.sv ----
`timescale 1ns/1ps
// ****************************************
// Comparator model
// ****************************************
module seq_analog #(
	parameter int INHIBIT_MV = 1000
) (
	// Levels in millivolts and volts
	input wire logic [15:0] vcc_mv,
	input wire logic [15:0] line_v,
	input wire logic [15:0] hv_v,
	// Comparator flags
	output logic [10:0] fl
);
	// Threshold comparators
	assign fl[10] = vcc_mv < INHIBIT_MV;
	assign fl[9] = vcc_mv >= 17000;
	assign fl[8] = vcc_mv < 8800;
	assign fl[7] = vcc_mv < 11000;
	assign fl[6] = vcc_mv > 28000;
	assign fl[5] = hv_v > 30;
	assign fl[4] = line_v > 30;
	assign fl[3] = line_v > 111;
	assign fl[2] = line_v < 101;
	assign fl[1] = line_v < 30;
	assign fl[0] = line_v > 240;
endmodule

// ---- seq_params.svh ----
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_STATE 8'h04
`define OFS_IRQ_ST 8'h08
`define OFS_IRQ_MASK 8'h0C

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_RUN_EN 0
`define CTRL_LATCH_CLR 1
`define RST_RUN_EN 1'b1
`define RST_IRQ_MASK 6'h00

// ****************************************
// Event bits in status and mask
// ****************************************
`define EV_W 6
`define EV_START 0
`define EV_UVLO 1
`define EV_LATCH 2
`define EV_BO_EXP 3
`define EV_HIGH 4
`define EV_LOW 5

// ****************************************
// Comparator flag positions
// ****************************************
`define FLAG_W 14
`define FL_VCC_INHIBIT 0
`define FL_VCC_START 1
`define FL_VCC_STOP 2
`define FL_VCC_SAVE 3
`define FL_VCC_OVP 4
`define FL_HV_SAVE_ON 5
`define FL_LINE_SAVE_ON 6
`define FL_BO_START 7
`define FL_BO_STOP 8
`define FL_DRV_DIS 9
`define FL_LINE_SEL 10
`define FL_PSM 11
`define FL_FAULT_AUTO 12
`define FL_FAULT_LATCH 13

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ 250
`define BO_TIME_US 54000
`define LH_TIME_US 300
`define HL_TIME_US 54000
`define TMR_W 24

`endif

// ---- seq_pkg.sv ----
`include "seq_params.svh"

package seq_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_CHARGE = 2'b00,
		ST_RUN = 2'b01,
		ST_SAVE = 2'b10,
		ST_LATCH = 2'b11
	} seq_state_type;

	typedef logic [`FLAG_W-1:0] flag_vec_type;
	typedef logic [`TMR_W-1:0] tmr_type;
	typedef logic [`EV_W-1:0] ev_vec_type;
endpackage

// ---- supply_props.sv ----
`timescale 1ns/1ps
// ****************************************
// Sequencer checker
// ****************************************
module supply_props
	import seq_pkg::*;
#(
	parameter tmr_type LH_CYCLES = 10
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Comparator flags
	input wire logic vcc_below_inhibit,
	input wire logic vcc_below_stop,
	input wire logic vcc_above_ovp,
	input wire logic line_above_bo_start,
	input wire logic line_above_line_select,
	// Sequencer outputs
	input wire logic startup_hv_en,
	input wire logic startup_line_en,
	input wire logic high_startup_current_en,
	input wire logic controller_en,
	input wire logic pfc_en,
	input wire logic flyback_en,
	input wire logic high_line_mode,
	input wire logic pfc_gain_high,
	input wire logic pfc_ontime_div3
);
	logic [10:0] above_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Run length of line above the line-select level
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !line_above_line_select)
			above_q <= 11'h000;
		else if (above_q != 11'h7FF)
			above_q <= above_q + 11'h001;
	end

	AST_INHIBIT_LOW: assert property (
		vcc_below_inhibit [*5] |-> !high_startup_current_en)
		else $error("High current while below inhibit");
	AST_START_PATHS_OFF: assert property (
		$rose(controller_en) |-> !startup_hv_en && !startup_line_en)
		else $error("Startup paths on at controller start");
	AST_STOP_STAGES_OFF: assert property (
		vcc_below_stop [*4] |-> !pfc_en && !flyback_en)
		else $error("Stages on below stop level");
	AST_OVP_LATCH: assert property (
		(flyback_en && vcc_above_ovp) [*3] |=> !controller_en)
		else $error("No latch-off on overvoltage");
	AST_FLYBACK_NEEDS_RUN: assert property (
		$rose(flyback_en) |-> controller_en)
		else $error("Flyback enabled without controller");
	AST_BO_RISE_STARTUP: assert property (
		$rose(line_above_bo_start) && controller_en && !flyback_en
		|-> ##[1:4] startup_hv_en && startup_line_en)
		else $error("Startups not on at line return");
	AST_LOW_AFTER_RESET: assert property (
		$rose(rst_b) |-> !high_line_mode)
		else $error("High line after reset");
	AST_HIGH_NOT_EARLY: assert property (
		$rose(high_line_mode) |-> above_q >= LH_CYCLES)
		else $error("High line before timer");
	AST_HIGH_LINE_GAIN: assert property (
		pfc_gain_high == high_line_mode
		&& pfc_ontime_div3 == high_line_mode)
		else $error("Gain or on time not following line mode");
endmodule

bind supply_startup_brownout_line_sequencer supply_props
	#(.LH_CYCLES(LH_CYCLES)) u_props (.*);

// ---- supply_startup_brownout_line_sequencer.sv ----
// Function
// - Below inhibit, only reduced startup current
// - At start threshold: startups off, controller on
// - Below stop: stages off, startups on
// - Savings mode regulates supply at savings threshold
// - Savings charge only above path turn-on level
// - Leaving savings mode turns both startups on
// - Supply overvoltage with flyback on latches off
// - Fault disables; restart at start, faults cleared
// - Flyback needs brown-out start and start threshold
// - Line rising past brown-out start restarts startups
// - Line below brown-out stop starts timer
// - After timer, drive-disable level stops stages
// - Brown-out timer outlasts one missing mains cycle
// - Power-up selects low-line mode
// - Low-to-high timer expiry selects high line
// - After high-to-low, inhibit until brown-out stop
// - High-to-low timer runs below line select
// - High line: high gain, on time third
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "seq_params.svh"

module supply_startup_brownout_line_sequencer
	import seq_pkg::*;
#(
	parameter tmr_type BO_CYCLES = `TMR_W'(`BO_TIME_US * `CLK_FREQ_MHZ),
	parameter tmr_type LH_CYCLES = `TMR_W'(`LH_TIME_US * `CLK_FREQ_MHZ),
	parameter tmr_type HL_CYCLES = `TMR_W'(`HL_TIME_US * `CLK_FREQ_MHZ)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Supply comparators
	input wire logic vcc_below_inhibit,
	input wire logic vcc_at_start,
	input wire logic vcc_below_stop,
	input wire logic vcc_below_savings,
	input wire logic vcc_above_ovp,
	// Startup input comparators
	input wire logic hv_above_savings_on,
	input wire logic line_above_savings_on,
	// Line-sense comparators
	input wire logic line_above_bo_start,
	input wire logic line_below_bo_stop,
	input wire logic line_below_drive_disable,
	input wire logic line_above_line_select,
	// Mode and faults
	input wire logic power_savings_mode,
	input wire logic fault_auto,
	input wire logic fault_latch,
	// Startup paths
	output logic startup_hv_en,
	output logic startup_line_en,
	output logic high_startup_current_en,
	// Stage enables
	output logic controller_en,
	output logic pfc_en,
	output logic flyback_en,
	// Line range
	output logic high_line_mode,
	output logic pfc_gain_high,
	output logic pfc_ontime_div3,
	// Interrupt
	output logic irq
);

	// ****************************************
	// Helpers
	// ****************************************

	// Saturating timer step
	function automatic tmr_type timer_next(input tmr_type cnt,
		input tmr_type lim);
		return (cnt == lim) ? cnt : cnt + `TMR_W'(1);
	endfunction

	// Byte-enable mask from sel
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// ****************************************
	// Flag synchronisation
	// ****************************************
	flag_if fl();
	flag_vec_type f;
	logic bo_start_prev_q;
	logic bo_rise;

	// Gather raw comparator flags
	always_comb begin
		fl.raw = '0;
		fl.raw[`FL_VCC_INHIBIT] = vcc_below_inhibit;
		fl.raw[`FL_VCC_START] = vcc_at_start;
		fl.raw[`FL_VCC_STOP] = vcc_below_stop;
		fl.raw[`FL_VCC_SAVE] = vcc_below_savings;
		fl.raw[`FL_VCC_OVP] = vcc_above_ovp;
		fl.raw[`FL_HV_SAVE_ON] = hv_above_savings_on;
		fl.raw[`FL_LINE_SAVE_ON] = line_above_savings_on;
		fl.raw[`FL_BO_START] = line_above_bo_start;
		fl.raw[`FL_BO_STOP] = line_below_bo_stop;
		fl.raw[`FL_DRV_DIS] = line_below_drive_disable;
		fl.raw[`FL_LINE_SEL] = line_above_line_select;
		fl.raw[`FL_PSM] = power_savings_mode;
		fl.raw[`FL_FAULT_AUTO] = fault_auto;
		fl.raw[`FL_FAULT_LATCH] = fault_latch;
	end

	flag_sync u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.fl(fl.sync_side)
	);

	assign f = fl.synced;

	// Edge of the brown-out start flag
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bo_start_prev_q <= 1'b0;
		end else begin
			bo_start_prev_q <= f[`FL_BO_START];
		end
	end

	assign bo_rise = f[`FL_BO_START] && !bo_start_prev_q;

	// ****************************************
	// Register bus
	// ****************************************
	logic ack_q;
	logic [31:0] dat_q;
	logic run_en_q;
	logic latch_clr_q;
	ev_vec_type irq_st_q;
	ev_vec_type irq_mask_q;
	ev_vec_type ev;
	logic irq_q;
	logic req;
	logic wr;
	logic [31:0] wd;
	logic [31:0] rd;

	assign req = cyc_i && stb_i && !ack_q;
	// Writes land at the edge where the master sees ack high
	assign wr = cyc_i && stb_i && ack_q && we_i;
	assign wd = dat_i & lane_mask(sel_i);

	// One-cycle acknowledge, writes land with it
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !we_i) begin
				dat_q <= rd;
			end
		end
	end

	// Control register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			run_en_q <= `RST_RUN_EN;
			latch_clr_q <= 1'b0;
		end else begin
			latch_clr_q <= wr && adr_i == `OFS_CTRL &&
				wd[`CTRL_LATCH_CLR];
			if (wr && adr_i == `OFS_CTRL && sel_i[0]) begin
				run_en_q <= dat_i[`CTRL_RUN_EN];
			end
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_st_q <= '0;
			irq_mask_q <= `RST_IRQ_MASK;
			irq_q <= 1'b0;
		end else begin
			if (wr && adr_i == `OFS_IRQ_ST) begin
				irq_st_q <= (irq_st_q & ~wd[`EV_W-1:0]) | ev;
			end else begin
				irq_st_q <= irq_st_q | ev;
			end
			if (wr && adr_i == `OFS_IRQ_MASK && sel_i[0]) begin
				irq_mask_q <= dat_i[`EV_W-1:0];
			end
			irq_q <= |(irq_st_q & irq_mask_q);
		end
	end

	// ****************************************
	// Startup and stage sequencing
	// ****************************************
	seq_state_type state_q;
	seq_state_type state_d;
	logic ctl_q;
	logic ctl_d;
	logic hv_q;
	logic hv_d;
	logic ln_q;
	logic ln_d;
	logic hi_cur_q;
	logic fly_q;
	logic pfc_q;
	logic bo_ok_q;
	logic bo_exp_q;
	logic ev_start;
	logic ev_uvlo;
	logic ev_latch;

	// Next state and controller enable
	always_comb begin
		state_d = state_q;
		ctl_d = ctl_q;
		ev_start = 1'b0;
		ev_uvlo = 1'b0;
		ev_latch = 1'b0;
		unique case (state_q)
			ST_CHARGE: begin
				if (f[`FL_VCC_START] && run_en_q) begin
					state_d = ST_RUN;
					ctl_d = !f[`FL_FAULT_AUTO] &&
						!f[`FL_FAULT_LATCH];
					ev_start = ctl_d;
				end
			end
			ST_RUN: begin
				if (f[`FL_VCC_STOP]) begin
					state_d = ST_CHARGE;
					ctl_d = 1'b0;
					ev_uvlo = 1'b1;
				end else if (f[`FL_FAULT_LATCH] ||
					(fly_q && f[`FL_VCC_OVP])) begin
					state_d = ST_LATCH;
					ctl_d = 1'b0;
					ev_latch = 1'b1;
				end else if (f[`FL_PSM] && ctl_q) begin
					state_d = ST_SAVE;
					ctl_d = 1'b0;
				end else if (bo_rise && !fly_q) begin
					state_d = ST_CHARGE;
					ctl_d = 1'b0;
				end else if (f[`FL_FAULT_AUTO] || !run_en_q) begin
					ctl_d = 1'b0;
				end
			end
			ST_SAVE: begin
				if (!f[`FL_PSM] || f[`FL_VCC_STOP]) begin
					state_d = ST_CHARGE;
				end
			end
			ST_LATCH: begin
				if (latch_clr_q) begin
					state_d = ST_CHARGE;
				end
			end
		endcase
	end

	// Startup path requests for the next state
	always_comb begin
		hv_d = 1'b0;
		ln_d = 1'b0;
		unique case (state_d)
			ST_CHARGE: begin
				hv_d = 1'b1;
				ln_d = 1'b1;
			end
			ST_SAVE: begin
				hv_d = f[`FL_VCC_SAVE] &&
					f[`FL_HV_SAVE_ON];
				ln_d = f[`FL_VCC_SAVE] &&
					f[`FL_LINE_SAVE_ON];
			end
			ST_RUN: begin
				hv_d = 1'b0;
				ln_d = 1'b0;
			end
			ST_LATCH: begin
				hv_d = 1'b0;
				ln_d = 1'b0;
			end
		endcase
	end

	// State, controller and startup registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_q <= ST_CHARGE;
			ctl_q <= 1'b0;
			hv_q <= 1'b0;
			ln_q <= 1'b0;
			hi_cur_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ctl_q <= ctl_d;
			hv_q <= hv_d;
			ln_q <= ln_d;
			hi_cur_q <= (hv_d || ln_d) &&
				!f[`FL_VCC_INHIBIT];
		end
	end

	// PFC and flyback stage enables
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fly_q <= 1'b0;
			pfc_q <= 1'b0;
		end else begin
			fly_q <= ctl_d && state_d == ST_RUN &&
				bo_ok_q;
			pfc_q <= ctl_d && state_d == ST_RUN && bo_ok_q;
		end
	end

	// ****************************************
	// Brown-out detection
	// ****************************************
	tmr_type bo_cnt_q;

	// Timer runs while line is below the stop level
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bo_cnt_q <= '0;
			bo_exp_q <= 1'b0;
		end else begin
			if (f[`FL_BO_STOP]) begin
				bo_cnt_q <= timer_next(bo_cnt_q, BO_CYCLES);
			end else begin
				bo_cnt_q <= '0;
			end
			bo_exp_q <= f[`FL_BO_STOP] &&
				bo_cnt_q == BO_CYCLES;
		end
	end

	// Line qualified for flyback operation
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bo_ok_q <= 1'b0;
		end else if (f[`FL_BO_START]) begin
			bo_ok_q <= 1'b1;
		end else if (bo_exp_q && f[`FL_DRV_DIS]) begin
			bo_ok_q <= 1'b0;
		end
	end

	// ****************************************
	// Line range detection
	// ****************************************
	tmr_type lh_cnt_q;
	tmr_type hl_cnt_q;
	logic high_q;
	logic inhib_q;
	logic go_high;
	logic go_low;

	assign go_high = !high_q && lh_cnt_q == LH_CYCLES;
	assign go_low = high_q && hl_cnt_q == HL_CYCLES;

	// Low-to-high and high-to-low timers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			lh_cnt_q <= '0;
			hl_cnt_q <= '0;
		end else begin
			if (f[`FL_LINE_SEL] && !high_q && !inhib_q) begin
				lh_cnt_q <= timer_next(lh_cnt_q, LH_CYCLES);
			end else begin
				lh_cnt_q <= '0;
			end
			if (high_q && !f[`FL_LINE_SEL]) begin
				hl_cnt_q <= timer_next(hl_cnt_q, HL_CYCLES);
			end else begin
				hl_cnt_q <= '0;
			end
		end
	end

	// Line mode and toggle inhibit
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			high_q <= 1'b0;
			inhib_q <= 1'b0;
		end else begin
			if (go_high) begin
				high_q <= 1'b1;
			end else if (go_low) begin
				high_q <= 1'b0;
			end
			if (go_low) begin
				inhib_q <= 1'b1;
			end else if (f[`FL_BO_STOP]) begin
				inhib_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Events and readback
	// ****************************************
	logic bo_exp_prev_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bo_exp_prev_q <= 1'b0;
		end else begin
			bo_exp_prev_q <= bo_exp_q;
		end
	end

	// Event vector
	always_comb begin
		ev = '0;
		ev[`EV_START] = ev_start;
		ev[`EV_UVLO] = ev_uvlo;
		ev[`EV_LATCH] = ev_latch;
		ev[`EV_BO_EXP] = bo_exp_q && !bo_exp_prev_q;
		ev[`EV_HIGH] = go_high;
		ev[`EV_LOW] = go_low;
	end

	// Read mux, unmapped reads as zero
	always_comb begin
		rd = 32'h0000_0000;
		unique case (adr_i)
			`OFS_CTRL: rd[`CTRL_RUN_EN] = run_en_q;
			`OFS_STATE: begin
				rd[1:0] = state_q;
				rd[2] = ctl_q;
				rd[3] = pfc_q;
				rd[4] = fly_q;
				rd[5] = high_q;
				rd[6] = bo_ok_q;
				rd[7] = bo_exp_q;
				rd[8] = inhib_q;
				rd[9] = hi_cur_q;
				rd[10] = hv_q;
				rd[11] = ln_q;
				rd[16+:`FLAG_W] = f;
			end
			`OFS_IRQ_ST: rd[`EV_W-1:0] = irq_st_q;
			`OFS_IRQ_MASK: rd[`EV_W-1:0] = irq_mask_q;
			default: rd = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign startup_hv_en = hv_q;
	assign startup_line_en = ln_q;
	assign high_startup_current_en = hi_cur_q;
	assign controller_en = ctl_q;
	assign pfc_en = pfc_q;
	assign flyback_en = fly_q;
	assign high_line_mode = high_q;
	assign pfc_gain_high = high_q;
	assign pfc_ontime_div3 = high_q;
	assign irq = irq_q;
endmodule

// ---- supply_startup_brownout_line_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "seq_params.svh"
module supply_startup_brownout_line_sequencer_bench;
	import seq_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
	logic ack_o, irq;
	logic [15:0] vcc_mv = 16'd500, line_v = 16'd120, hv_v = 16'd120;
	logic [10:0] fl;
	logic vcc_below_inhibit, vcc_at_start, vcc_below_stop;
	logic vcc_below_savings, vcc_above_ovp, hv_above_savings_on;
	logic line_above_savings_on, line_above_bo_start;
	logic line_below_bo_stop, line_below_drive_disable;
	logic line_above_line_select;
	logic power_savings_mode = 1'b0, fault_auto = 1'b0;
	logic fault_latch = 1'b0;
	logic startup_hv_en, startup_line_en, high_startup_current_en;
	logic controller_en, pfc_en, flyback_en;
	logic high_line_mode, pfc_gain_high, pfc_ontime_div3;
	int fails = 0, n_tests = 0, cyc_n = 0;

	assign {vcc_below_inhibit, vcc_at_start, vcc_below_stop,
		vcc_below_savings, vcc_above_ovp, hv_above_savings_on,
		line_above_savings_on, line_above_bo_start, line_below_bo_stop,
		line_below_drive_disable, line_above_line_select} = fl;

	// Short timers keep the run brief
	supply_startup_brownout_line_sequencer #(.BO_CYCLES(20),
		.LH_CYCLES(10), .HL_CYCLES(20)) dut (.*);
	seq_analog ana (.*);

	// Clock and hang guard
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			fails++;
			complete_run;
		end
	end

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Wait n rising edges, then settle at the falling edge
	task automatic at(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic sv(input logic [15:0] v, l, h);
		@(posedge clk_sys);
		vcc_mv <= v;
		line_v <= l;
		hv_v <= h;
	endtask

	// One classic Wishbone cycle, ack and data taken at a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		chk(ack_o, 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic t_reset;
		at(3);
		chk(high_line_mode, 1'b0);
		chk({startup_hv_en, startup_line_en, high_startup_current_en},
			3'b110);
		wb(1'b0, `OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		wb(1'b0, `OFS_IRQ_MASK, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask

	task automatic t_start;
		sv(12000, 120, 120);
		at(4);
		chk(high_startup_current_en, 1'b1);
		sv(17500, 120, 120);
		at(4);
		chk({startup_hv_en, startup_line_en, controller_en, pfc_en,
			flyback_en}, 5'b00111);
		chk(irq, 1'b0);
		wb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
		at(1);
		chk(irq, 1'b1);
		wb(1'b1, `OFS_IRQ_ST, 32'h0000_0001);
		at(1);
		chk(irq, 1'b0);
	endtask

	task automatic t_line;
		sv(17500, 300, 120);
		at(7);
		chk(high_line_mode, 1'b0);
		at(8);
		chk({high_line_mode, pfc_gain_high, pfc_ontime_div3},
			3'b111);
		sv(17500, 200, 120);
		at(18);
		sv(17500, 300, 120);
		at(2);
		sv(17500, 200, 120);
		at(18);
		chk(high_line_mode, 1'b1);
		at(8);
		chk(high_line_mode, 1'b0);
		sv(17500, 300, 120);
		at(30);
		chk(high_line_mode, 1'b0);
		sv(17500, 95, 120);
		at(4);
		sv(17500, 300, 120);
		at(15);
		chk(high_line_mode, 1'b1);
		sv(17500, 120, 120);
		at(26);
	endtask

	task automatic t_brown;
		sv(17500, 20, 120);
		at(18);
		chk({pfc_en, flyback_en}, 2'b11);
		at(10);
		chk({pfc_en, flyback_en}, 2'b00);
		sv(12000, 20, 120);
		at(4);
		sv(12000, 120, 120);
		at(4);
		chk({startup_hv_en, startup_line_en}, 2'b11);
		sv(17500, 120, 120);
		at(4);
		chk({controller_en, flyback_en}, 2'b11);
		sv(8000, 120, 120);
		at(4);
		chk({pfc_en, flyback_en, startup_hv_en, startup_line_en},
			4'b0011);
		sv(17500, 120, 120);
		at(4);
	endtask

	task automatic t_fault;
		sv(29000, 120, 120);
		at(4);
		chk(controller_en, 1'b0);
		sv(17500, 120, 120);
		at(4);
		chk({controller_en, startup_hv_en}, 2'b00);
		wb(1'b1, `OFS_CTRL, 32'h0000_0003);
		at(6);
		chk(controller_en, 1'b1);
		@(posedge clk_sys);
		fault_auto <= 1'b1;
		at(4);
		chk(controller_en, 1'b0);
		sv(8000, 120, 120);
		at(4);
		sv(17500, 120, 120);
		at(4);
		chk(controller_en, 1'b0);
		@(posedge clk_sys);
		fault_auto <= 1'b0;
		sv(8000, 120, 120);
		at(4);
		sv(17500, 120, 120);
		at(4);
		chk(controller_en, 1'b1);
	endtask

	task automatic t_save;
		@(posedge clk_sys);
		power_savings_mode <= 1'b1;
		sv(10000, 20, 50);
		at(4);
		chk({startup_hv_en, startup_line_en}, 2'b10);
		sv(11500, 20, 50);
		at(4);
		chk({startup_hv_en, startup_line_en}, 2'b00);
		sv(10000, 50, 20);
		at(4);
		chk({startup_hv_en, startup_line_en}, 2'b01);
		@(posedge clk_sys);
		power_savings_mode <= 1'b0;
		at(4);
		chk({startup_hv_en, startup_line_en}, 2'b11);
		sv(17500, 120, 120);
		at(4);
		chk(controller_en, 1'b1);
	endtask

	// Reset, then each scenario in turn
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset;
		t_start;
		t_line;
		t_brown;
		t_fault;
		t_save;
		complete_run;
	end
endmodule
